// ### src/aps_dev.sv
// device end: acceleration constants and voc state commands
//
// How it works
// - 0x6100 with 12 bytes sets acceleration constants
// - acceleration constants accepted only in idle
// - reset restores factory default constants
// - words one, two: filter constants times ten
// - words three, four: lag times in tenths
// - read 0x6181 returns 8 state bytes, crcs
// - read works always; idle gives frozen state
// - snapshot refreshed every measurement interval
// - state survives stop; cleared only by reset
// - write 0x6181 stores state, then 20 ms
// - written state loaded once at next start
// - state write during measurement is ignored
// - host may restore saved state before start
// - each crc covers the two preceding bytes
`timescale 1ns/1ps
module aps_dev
  import aps_pkg::*;
#(
  parameter int POST_CYCLES = POST_CYC,
  parameter logic [15:0] DEF_K = 16'h0000,
  parameter logic [15:0] DEF_P = 16'h0000,
  parameter logic [15:0] DEF_LAG1 = 16'h0000,
  parameter logic [15:0] DEF_LAG2 = 16'h0000
) (
  input wire logic clock, // system clock
  input wire logic rst_b, // sync reset, active low
  aps_link_if.dev lnk, // command link
  input wire logic meas_running, // measure mode active
  input wire logic meas_start, // measurement begins, pulse
  input wire logic meas_tick, // measurement interval, pulse
  input wire logic [63:0] voc_state_in, // live algorithm state
  output logic [15:0] accel_k, // filter constant k, x10
  output logic [15:0] accel_p, // filter constant p, x10
  output logic [15:0] lag_time_one, // lag one, 0.1 s units
  output logic [15:0] lag_time_two, // lag two, 0.1 s units
  output logic voc_load, // load state into algorithm, pulse
  output logic [63:0] voc_load_state, // state to load
  output logic crc_fault // frame with bad length or crc, pulse
);

  ////////////////////////////////////////////////////////////////
  // state and registers

  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_RX = 2'b01,
    DS_BUSY = 2'b10,
    DS_TX = 2'b11
  } aps_dstate_t;

  aps_dstate_t state_q, state_d;
  logic [95:0] rx_q;
  logic [3:0] rx_cnt_q;
  logic rx_over_q;
  logic [15:0] code_q;
  logic rd_q;
  logic [31:0] busy_cnt_q;
  logic [95:0] tx_q;
  logic [3:0] tx_idx_q;
  logic [7:0] rbyte_q;
  logic rbyte_vld_q;
  logic [63:0] snap_q;
  logic pend_q;
  logic [63:0] pend_state_q;
  logic [15:0] k_q, p_q, lag1_q, lag2_q;
  logic voc_load_q;
  logic [63:0] voc_load_state_q;
  logic crc_fault_q;

  ////////////////////////////////////////////////////////////////
  // decode

  wire known_code = (lnk.code == CMD_ACCEL) || (lnk.code == CMD_VOC);
  wire take_read = lnk.start && lnk.is_read && (lnk.code == CMD_VOC);
  wire take_write = lnk.start && !lnk.is_read && known_code;
  wire rx_take = lnk.wbyte_vld && (state_q == DS_RX);
  wire frame_end = lnk.wend && (state_q == DS_RX);
  wire len_ok = (rx_cnt_q == FRAME_CNT) && !rx_over_q;
  wire crc_ok = aps_frame_ok(rx_q);
  wire frame_good = frame_end && len_ok && crc_ok;
  wire frame_bad = frame_end && !(len_ok && crc_ok);
  wire [63:0] rx_data = aps_frame_data(rx_q);
  wire set_accel = frame_good && (code_q == CMD_ACCEL) && !meas_running;
  wire set_voc = frame_good && (code_q == CMD_VOC) && !meas_running;
  wire busy_done = (busy_cnt_q == 32'(POST_CYCLES - 1));
  wire tx_take = lnk.rd_req && (state_q == DS_TX);
  wire tx_last = tx_take && (tx_idx_q == LAST_BYTE);

  ////////////////////////////////////////////////////////////////
  // command sequencer

  always_comb begin
    state_d = state_q;
    case (state_q)
      DS_IDLE: begin
        if (take_read) begin
          state_d = DS_BUSY;
        end else if (take_write) begin
          state_d = DS_RX;
        end
      end
      DS_RX: begin
        if (lnk.wend) begin
          state_d = DS_BUSY;
        end
      end
      DS_BUSY: begin
        if (busy_done) begin
          state_d = rd_q ? DS_TX : DS_IDLE;
        end
      end
      DS_TX: begin
        if (tx_last) begin
          state_d = DS_IDLE;
        end
      end
      default: state_d = DS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= DS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // command capture and processing delay

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      code_q <= '0;
      rd_q <= 1'b0;
      busy_cnt_q <= '0;
    end else begin
      if (state_q == DS_IDLE && (take_read || take_write)) begin
        code_q <= lnk.code;
        rd_q <= take_read;
      end
      busy_cnt_q <= (state_q == DS_BUSY) ? busy_cnt_q + 32'd1 : '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // payload receive

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_q <= '0;
      rx_cnt_q <= '0;
      rx_over_q <= 1'b0;
    end else if (state_q == DS_IDLE) begin
      rx_cnt_q <= '0;
      rx_over_q <= 1'b0;
    end else if (rx_take) begin
      if (rx_cnt_q == FRAME_CNT) begin
        rx_over_q <= 1'b1;
      end else begin
        rx_q <= {rx_q[87:0], lnk.wbyte};
        rx_cnt_q <= rx_cnt_q + 4'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // read-back of the state snapshot

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_q <= '0;
      tx_idx_q <= '0;
      rbyte_q <= '0;
      rbyte_vld_q <= 1'b0;
    end else begin
      rbyte_vld_q <= tx_take;
      if (state_q == DS_IDLE && take_read) begin
        tx_q <= aps_frame(snap_q);
        tx_idx_q <= '0;
      end else if (tx_take) begin
        rbyte_q <= aps_byte(tx_q, tx_idx_q);
        tx_idx_q <= tx_idx_q + 4'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // acceleration constants, volatile

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      k_q <= DEF_K;
      p_q <= DEF_P;
      lag1_q <= DEF_LAG1;
      lag2_q <= DEF_LAG2;
    end else if (set_accel) begin
      k_q <= rx_data[63:48];
      p_q <= rx_data[47:32];
      lag1_q <= rx_data[31:16];
      lag2_q <= rx_data[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // voc state snapshot and pending restore

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      snap_q <= '0;
      pend_q <= 1'b0;
      pend_state_q <= '0;
      voc_load_q <= 1'b0;
      voc_load_state_q <= '0;
      crc_fault_q <= 1'b0;
    end else begin
      crc_fault_q <= frame_bad;
      voc_load_q <= meas_start && pend_q;
      if (meas_running && meas_tick) begin
        snap_q <= voc_state_in;
      end
      if (meas_start && pend_q) begin
        voc_load_state_q <= pend_state_q;
        pend_q <= 1'b0;
      end
      if (set_voc) begin
        pend_q <= 1'b1;
        pend_state_q <= rx_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign lnk.rbyte = rbyte_q;
  assign lnk.rbyte_vld = rbyte_vld_q;
  assign lnk.busy = (state_q == DS_BUSY);
  assign accel_k = k_q;
  assign accel_p = p_q;
  assign lag_time_one = lag1_q;
  assign lag_time_two = lag2_q;
  assign voc_load = voc_load_q;
  assign voc_load_state = voc_load_state_q;
  assign crc_fault = crc_fault_q;

endmodule

// ### src/aps_pkg.sv
// shared constants, types and frame helpers for the command link
package aps_pkg;

  localparam logic [15:0] CMD_ACCEL = 16'h6100;
  localparam logic [15:0] CMD_VOC = 16'h6181;
  localparam int WORDS = 4;
  localparam int FRAME_BYTES = 12;
  localparam logic [3:0] LAST_BYTE = 4'hb;
  localparam logic [3:0] FRAME_CNT = 4'hc;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hff;
  // filters carry ten times the value, lags carry tenths of a second
  localparam int ACC_SCALE = 10;
  localparam int POST_TIME_MS = 20;
  localparam int CLK_HZ = 100_000_000;
  localparam int POST_CYC = POST_TIME_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    OP_ACCEL = 2'b00,
    OP_GET_VOC = 2'b01,
    OP_SET_VOC = 2'b10
  } aps_op_t;

  // crc over one 16-bit word, msb first
  function automatic logic [7:0] aps_crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // four words, each followed by its own crc byte
  function automatic logic [95:0] aps_frame(input logic [63:0] d);
    logic [95:0] f;
    f = '0;
    for (int i = 0; i < WORDS; i++) begin
      f[95-24*i -: 24] = {d[63-16*i -: 16], aps_crc8(d[63-16*i -: 16])};
    end
    return f;
  endfunction

  function automatic logic [63:0] aps_frame_data(input logic [95:0] f);
    logic [63:0] d;
    d = '0;
    for (int i = 0; i < WORDS; i++) begin
      d[63-16*i -: 16] = f[95-24*i -: 16];
    end
    return d;
  endfunction

  function automatic logic aps_frame_ok(input logic [95:0] f);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < WORDS; i++) begin
      ok = ok & (f[79-24*i -: 8] == aps_crc8(f[95-24*i -: 16]));
    end
    return ok;
  endfunction

  function automatic logic [7:0] aps_byte(input logic [95:0] f, input logic [3:0] idx);
    return f[95-8*idx -: 8];
  endfunction

endpackage

// ### src/aps_link_if.sv
// byte-level command link between host controller and device
`timescale 1ns/1ps
interface aps_link_if;
  logic start;
  logic [15:0] code;
  logic is_read;
  logic wbyte_vld;
  logic [7:0] wbyte;
  logic wend;
  logic rd_req;
  logic rbyte_vld;
  logic [7:0] rbyte;
  logic busy;

  modport host (
    output start, code, is_read, wbyte_vld, wbyte, wend, rd_req,
    input rbyte_vld, rbyte, busy
  );

  modport dev (
    input start, code, is_read, wbyte_vld, wbyte, wend, rd_req,
    output rbyte_vld, rbyte, busy
  );
endinterface

// ### src/aps_host.sv
// host end: issues the three commands and keeps the waits
`timescale 1ns/1ps
module aps_host
  import aps_pkg::*;
#(
  parameter int WAIT_CYCLES = POST_CYC
) (
  input wire logic clock, // system clock
  input wire logic rst_b, // sync reset, active low
  aps_link_if.host lnk, // command link
  input wire logic req_valid, // command request
  input wire aps_op_t req_op, // which command
  input wire logic [63:0] req_data, // four words or eight state bytes
  input wire logic meas_running, // device in measure mode
  output logic req_ready, // ready for a request
  output logic refused, // request refused in measure mode, pulse
  output logic rsp_valid, // read data valid, pulse
  output logic [63:0] rsp_data, // state read back
  output logic rsp_crc_err // read frame crc mismatch
);

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SEND = 2'b01,
    HS_WAIT = 2'b10,
    HS_READ = 2'b11
  } aps_hstate_t;

  aps_hstate_t state_q;
  logic [95:0] frame_q;
  logic [3:0] idx_q;
  logic rd_q;
  logic [31:0] wait_q;
  logic pend_q;
  logic start_q, is_read_q, wvld_q, wend_q, refused_q, rsp_valid_q, crc_err_q;
  logic [15:0] code_q;
  logic [7:0] wbyte_q;
  logic [63:0] rsp_q;

  ////////////////////////////////////////////////////////////////
  // decode

  wire needs_idle = (req_op != OP_GET_VOC);
  wire take = req_valid && (state_q == HS_IDLE);
  wire blocked = take && needs_idle && meas_running;
  wire wait_done = (wait_q == 32'(WAIT_CYCLES - 1));
  wire rd_req = (state_q == HS_READ) && !pend_q && !lnk.busy;
  wire rd_last = lnk.rbyte_vld && (idx_q == LAST_BYTE);

  ////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= HS_IDLE;
      frame_q <= '0;
      idx_q <= '0;
      rd_q <= 1'b0;
      wait_q <= '0;
      pend_q <= 1'b0;
      start_q <= 1'b0;
      is_read_q <= 1'b0;
      code_q <= '0;
      wvld_q <= 1'b0;
      wbyte_q <= '0;
      wend_q <= 1'b0;
      refused_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      crc_err_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      wvld_q <= 1'b0;
      wend_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      refused_q <= blocked;
      case (state_q)
        HS_IDLE: begin
          if (take && !blocked) begin
            start_q <= 1'b1;
            code_q <= (req_op == OP_ACCEL) ? CMD_ACCEL : CMD_VOC;
            is_read_q <= (req_op == OP_GET_VOC);
            rd_q <= (req_op == OP_GET_VOC);
            frame_q <= aps_frame(req_data);
            idx_q <= '0;
            wait_q <= '0;
            state_q <= (req_op == OP_GET_VOC) ? HS_WAIT : HS_SEND;
          end
        end
        HS_SEND: begin
          if (idx_q == FRAME_CNT) begin
            wend_q <= 1'b1;
            state_q <= HS_WAIT;
          end else begin
            wvld_q <= 1'b1;
            wbyte_q <= aps_byte(frame_q, idx_q);
            idx_q <= idx_q + 4'd1;
          end
        end
        HS_WAIT: begin
          wait_q <= wait_q + 32'd1;
          idx_q <= '0;
          if (wait_done) begin
            state_q <= rd_q ? HS_READ : HS_IDLE;
          end
        end
        HS_READ: begin
          if (rd_req) begin
            pend_q <= 1'b1;
          end
          if (lnk.rbyte_vld) begin
            pend_q <= 1'b0;
            frame_q <= {frame_q[87:0], lnk.rbyte};
            idx_q <= idx_q + 4'd1;
          end
          if (rd_last) begin
            rsp_valid_q <= 1'b1;
            rsp_q <= aps_frame_data({frame_q[87:0], lnk.rbyte});
            crc_err_q <= !aps_frame_ok({frame_q[87:0], lnk.rbyte});
            state_q <= HS_IDLE;
          end
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign lnk.start = start_q;
  assign lnk.code = code_q;
  assign lnk.is_read = is_read_q;
  assign lnk.wbyte_vld = wvld_q;
  assign lnk.wbyte = wbyte_q;
  assign lnk.wend = wend_q;
  assign lnk.rd_req = rd_req;
  assign req_ready = (state_q == HS_IDLE);
  assign refused = refused_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_q;
  assign rsp_crc_err = crc_err_q;

endmodule

// ### tb/aps_checker.sv
// concurrent checks on the command link between host and device
`timescale 1ns/1ps
module aps_checker
  import aps_pkg::*;
#(
  parameter int POST_CYCLES = POST_CYC
) (
  input wire logic clock, // system clock
  input wire logic rst_b, // sync reset, active low
  input wire logic start, // command frame begins
  input wire logic [15:0] code, // command code
  input wire logic is_read, // read transfer follows
  input wire logic wbyte_vld, // payload byte valid
  input wire logic wend, // end of payload
  input wire logic rd_req, // read byte request
  input wire logic rbyte_vld, // read byte valid
  input wire logic busy // processing delay
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////
  int busy_len_q;
  always_ff @(posedge clock) begin
    if (!rst_b || !busy) begin
      busy_len_q <= 0;
    end else begin
      busy_len_q <= busy_len_q + 1;
    end
  end

  ////////////////////////////////////////////////////////////////
  sequence wr_start_s;
    start && !is_read;
  endsequence
  sequence wr_bytes_s;
    wbyte_vld [*8] ##1 wbyte_vld [*4];
  endsequence

  wr_walk_a: assert property (wr_start_s |=> wr_bytes_s ##1 wend)
    else $error("write frame not twelve bytes then end");
  code_legal_a: assert property (start |-> (code == CMD_ACCEL || code == CMD_VOC))
    else $error("unknown command code on link");
  read_code_a: assert property (start && is_read |-> code == CMD_VOC)
    else $error("read transfer with wrong code");
  rd_delay_a: assert property (start && is_read |=> busy)
    else $error("no read delay after read start");
  wr_post_a: assert property (wend |=> busy)
    else $error("no processing delay after payload");
  post_len_a: assert property ($fell(busy) |-> busy_len_q == POST_CYCLES)
    else $error("processing delay of wrong length");
  rd_answer_a: assert property (rd_req |=> rbyte_vld)
    else $error("read byte not answered next cycle");
  rd_cause_a: assert property (rbyte_vld |-> $past(rd_req))
    else $error("read byte without request");
  no_rd_busy_a: assert property (rd_req |-> !busy)
    else $error("read requested during delay");
endmodule

// ### tb/algo_param_state_commands_bench.sv
// self-checking bench: host and device joined, plus a device fed faulty frames
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module algo_param_state_commands_bench;
  import aps_pkg::*;
  localparam int PC = 20;
  localparam logic [95:0] GOOD = {4{24'hbeef_92}};
  localparam logic [95:0] BAD = {24'hbeef_00, {3{24'hbeef_92}}};
  logic clock, rst_b, req_valid, meas_running, meas_start, meas_tick;
  aps_op_t req_op;
  logic [63:0] req_data, voc_state_in, rsp_data, load_w, load2_w, got, ld_st;
  logic req_ready, refused, rsp_valid, rsp_crc_err, voc_load, voc_load2, crc_fault, crc_fault2;
  logic saw_ref, got_err, flt, bad_main;
  logic [15:0] k, p, l1, l2, k2;
  int miscompares = 0;
  int check_count = 0;
  int nbytes, nloads, nloads2;
  logic [7:0] wb [0:15];
  aps_link_if lnk();
  aps_link_if lnk2();

  aps_host #(.WAIT_CYCLES(PC)) aps_host_i (.clock(clock), .rst_b(rst_b), .lnk(lnk.host),
    .req_valid(req_valid), .req_op(req_op), .req_data(req_data), .meas_running(meas_running),
    .req_ready(req_ready), .refused(refused), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_crc_err(rsp_crc_err));
  aps_dev #(.POST_CYCLES(PC)) aps_dev_i (.clock(clock), .rst_b(rst_b), .lnk(lnk.dev),
    .meas_running(meas_running), .meas_start(meas_start), .meas_tick(meas_tick),
    .voc_state_in(voc_state_in), .accel_k(k), .accel_p(p), .lag_time_one(l1), .lag_time_two(l2),
    .voc_load(voc_load), .voc_load_state(load_w), .crc_fault(crc_fault));
  aps_dev #(.POST_CYCLES(PC)) aps_dev_fault_i (.clock(clock), .rst_b(rst_b), .lnk(lnk2.dev),
    .meas_running(meas_running), .meas_start(meas_start), .meas_tick(meas_tick),
    .voc_state_in(voc_state_in), .accel_k(k2), .accel_p(), .lag_time_one(), .lag_time_two(),
    .voc_load(voc_load2), .voc_load_state(load2_w), .crc_fault(crc_fault2));
  aps_checker #(.POST_CYCLES(PC)) aps_checker_i (.clock(clock), .rst_b(rst_b), .start(lnk.start),
    .code(lnk.code), .is_read(lnk.is_read), .wbyte_vld(lnk.wbyte_vld), .wend(lnk.wend),
    .rd_req(lnk.rd_req), .rbyte_vld(lnk.rbyte_vld), .busy(lnk.busy));

  ////////////////////////////////////////////////////////////////
  // link and user-side monitors
  always @(posedge clock) begin
    if (lnk.start) nbytes <= 0;
    else if (lnk.wbyte_vld && nbytes < 16) begin
      wb[nbytes] <= lnk.wbyte;
      nbytes <= nbytes + 1;
    end
    if (refused) saw_ref <= 1'b1;
    if (rsp_valid) begin
      got <= rsp_data;
      got_err <= rsp_crc_err;
    end
    if (voc_load) begin
      nloads <= nloads + 1;
      ld_st <= load_w;
    end
    if (voc_load2) nloads2 <= nloads2 + 1;
    if (crc_fault2) flt <= 1'b1;
    if (crc_fault) bad_main <= 1'b1;
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_ready();
    int i;
    for (i = 0; i < 2000 && req_ready !== 1'b1; i++) @(negedge clock);
    if (i == 2000) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic issue(input aps_op_t op, input logic [63:0] d);
    saw_ref = 1'b0;
    got = '0;
    @(negedge clock);
    wait_ready();
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    req_data <= d;
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
    wait_ready();
    repeat (3) @(posedge clock);
  endtask

  task automatic mpulse(input logic s, input logic t);
    @(posedge clock);
    meas_start <= s;
    meas_tick <= t;
    @(posedge clock);
    meas_start <= 1'b0;
    meas_tick <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // drives a write frame straight onto the second link
  task automatic send2(input logic [15:0] c, input logic [95:0] f);
    int i;
    flt = 1'b0;
    @(posedge clock);
    lnk2.start <= 1'b1;
    lnk2.code <= c;
    for (i = 0; i < FRAME_BYTES; i++) begin
      @(posedge clock);
      lnk2.start <= 1'b0;
      lnk2.wbyte_vld <= 1'b1;
      lnk2.wbyte <= f[95-8*i -: 8];
    end
    @(posedge clock);
    lnk2.wbyte_vld <= 1'b0;
    lnk2.wbyte <= ~lnk2.wbyte;
    lnk2.wend <= 1'b1;
    @(posedge clock);
    lnk2.wend <= 1'b0;
    repeat (PC + 5) @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_accel();
    `CHK("accel at reset", 64'h0000_0000_0000_0000, {k, p, l1, l2})
    issue(OP_ACCEL, 64'hbeef_0102_0304_0506);
    `CHK("first word and crc", 24'hbeef_92, {wb[0], wb[1], wb[2]})
    `CHK("lag two on wire", 16'h0506, {wb[9], wb[10]})
    `CHK("payload bytes", FRAME_BYTES, nbytes)
    `CHK("accel outputs", 64'hbeef_0102_0304_0506, {k, p, l1, l2})
  endtask

  task automatic t_refuse();
    meas_running <= 1'b1;
    issue(OP_ACCEL, 64'h1111_2222_3333_4444);
    `CHK("accel refused", 1'b1, saw_ref)
    `CHK("accel kept", 64'hbeef_0102_0304_0506, {k, p, l1, l2})
    issue(OP_SET_VOC, 64'h1111_2222_3333_4444);
    `CHK("state write refused", 1'b1, saw_ref)
  endtask

  task automatic t_get();
    voc_state_in <= 64'h0123_4567_89ab_cdef;
    mpulse(1'b0, 1'b1);
    issue(OP_GET_VOC, '0);
    `CHK("state in measure", 64'h0123_4567_89ab_cdef, got)
    `CHK("read crc", 1'b0, got_err)
    meas_running <= 1'b0;
    voc_state_in <= 64'hfedc_ba98_7654_3210;
    mpulse(1'b0, 1'b1);
    issue(OP_GET_VOC, '0);
    `CHK("frozen in idle", 64'h0123_4567_89ab_cdef, got)
    nloads = 0;
    meas_running <= 1'b1;
    mpulse(1'b1, 1'b0);
    issue(OP_GET_VOC, '0);
    `CHK("kept over restart", 64'h0123_4567_89ab_cdef, got)
    `CHK("no load without write", 0, nloads)
  endtask

  task automatic t_set();
    meas_running <= 1'b0;
    issue(OP_SET_VOC, 64'h5566_7788_99aa_bbcc);
    `CHK("state payload", 16'h5566, {wb[0], wb[1]})
    `CHK("good frames no fault", 1'b0, bad_main)
    meas_running <= 1'b1;
    mpulse(1'b1, 1'b0);
    `CHK("loaded once", 1, nloads)
    `CHK("loaded state", 64'h5566_7788_99aa_bbcc, ld_st)
    meas_running <= 1'b0;
    mpulse(1'b0, 1'b0);
    meas_running <= 1'b1;
    mpulse(1'b1, 1'b0);
    `CHK("not loaded again", 1, nloads)
  endtask

  task automatic t_fault();
    meas_running <= 1'b0;
    send2(CMD_ACCEL, BAD);
    `CHK("bad crc flagged", 1'b1, flt)
    `CHK("bad frame dropped", 16'h0000, k2)
    send2(16'h1234, GOOD);
    `CHK("unknown code no fault", 1'b0, flt)
    `CHK("unknown code ignored", 16'h0000, k2)
    send2(CMD_ACCEL, GOOD);
    `CHK("good frame taken", 16'hbeef, k2)
    nloads2 = 0;
    meas_running <= 1'b1;
    send2(CMD_VOC, GOOD);
    mpulse(1'b1, 1'b0);
    `CHK("write in measure ignored", 0, nloads2)
  endtask

  task automatic t_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    meas_running <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    `CHK("defaults back", 64'h0000_0000_0000_0000, {k, p, l1, l2})
    `CHK("fault end defaults", 16'h0000, k2)
    issue(OP_GET_VOC, '0);
    `CHK("state cleared", 64'h0000_0000_0000_0000, got)
    issue(OP_SET_VOC, 64'h0123_4567_89ab_cdef);
    meas_running <= 1'b1;
    mpulse(1'b1, 1'b0);
    `CHK("saved state restored", 64'h0123_4567_89ab_cdef, ld_st)
  endtask

  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_op = OP_ACCEL;
    req_data = '0;
    meas_running = 1'b0;
    meas_start = 1'b0;
    meas_tick = 1'b0;
    voc_state_in = '0;
    nbytes = 0;
    nloads = 0;
    nloads2 = 0;
    bad_main = 1'b0;
    lnk2.start = 1'b0;
    lnk2.code = '0;
    lnk2.is_read = 1'b0;
    lnk2.wbyte_vld = 1'b0;
    lnk2.wbyte = '0;
    lnk2.wend = 1'b0;
    lnk2.rd_req = 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_accel();
    t_refuse();
    t_get();
    t_set();
    t_fault();
    t_reset();
    summarize();
  end
endmodule
